/* hdl/cks_clock_ctrl.sv */
// clock control: oscillator stop interlock, clock status and peripheral source select
//
// Function
// - internal oscillator stops only when CPU elsewhere
// - X1/external input stops only when CPU elsewhere
// - XT1 stops only when CPU off subclock
// - internal oscillator and X1 each have a stop flag, XT1 a run flag
// - each peripheral mux offers only permitted sources
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module cks_clock_ctrl (
   input  wire logic                               clock_i,
   input  wire logic                               reset_n_i,
   input  wire cks_pkg::cks_wb_req_s               wb_req_i,
   output cks_pkg::cks_wb_rsp_s                    wb_rsp_o,
   input  wire logic                               subclock_i,
   input  wire logic                               low_speed_osc_clock_i,
   input  wire logic                               timer50_output_i,
   input  wire logic                               timer52_output_i,
   input  wire logic                               timer_h1_output_i,
   input  wire logic                               timer00_pin_clock_i,
   input  wire logic                               timer52_pin_clock_i,
   output logic                                    main_clock_status_o,
   output logic                                    cpu_clock_status_o,
   output logic                                    internal_hs_osc_stop_o,
   output logic                                    high_speed_osc_stop_o,
   output logic                                    subclock_osc_select_o,
   output logic [cks_pkg::NUM_PERIPH-1:0]          periph_tick_o
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic                                     ack;
      logic [31:0]                              rdat;
      logic                                     mcm;
      logic                                     css;
      logic                                     main_clock_status;
      logic                                     cpu_clock_status;
      logic                                     ihs_stop;
      logic                                     hs_stop;
      logic                                     sub_sel;
      logic                                     refused;
      logic [2:0]                               cnt;
      logic [cks_pkg::NUM_PERIPH*cks_pkg::SRC_W-1:0] sel;
      logic [cks_pkg::NUM_ASYNC-1:0]            sync1;
      logic [cks_pkg::NUM_ASYNC-1:0]            sync2;
      logic [cks_pkg::NUM_ASYNC-1:0]            prev;
      logic [cks_pkg::NUM_PERIPH-1:0]           tick;
   } cks_state_s;

   localparam cks_state_s ST_RST = '{
      ack: 1'b0, rdat: 32'h0000_0000,
      mcm: cks_pkg::RST_MAIN_SEL, css: cks_pkg::RST_CPU_SEL,
      main_clock_status: cks_pkg::RST_MAIN_SEL, cpu_clock_status: cks_pkg::RST_CPU_SEL,
      ihs_stop: cks_pkg::RST_IHS_STOP, hs_stop: cks_pkg::RST_HS_STOP,
      sub_sel: cks_pkg::RST_SUB_SEL, refused: 1'b0, cnt: 3'h0,
      sel: cks_pkg::RST_SEL, sync1: 7'h00, sync2: 7'h00, prev: 7'h00,
      tick: 15'h0000};

   cks_state_s st_q;
   cks_state_s st_d;

   logic                                          req;
   logic                                          wr;
   logic                                          pend;
   logic                                          ihs_ok;
   logic                                          hs_ok;
   logic                                          sub_ok;
   logic [cks_pkg::NUM_ASYNC-1:0]                 async_in;
   logic [cks_pkg::NUM_SRC-1:0]                   src;
   logic [cks_pkg::NUM_PERIPH-1:0]                mux_tick;
   logic [cks_pkg::NUM_PERIPH*cks_pkg::SRC_W-1:0] sel_wr;
   logic [1:0][31:0]                              rd_sel;
   logic [31:0]                                   ctrl_rd;
   logic [31:0]                                   stat_rd;

   // ***************************************************************
   // source ticks
   // ***************************************************************
   // bit order follows the source codes 1..7; code 0 is fprs, a tick every cycle
   assign async_in = {timer52_pin_clock_i, timer00_pin_clock_i, timer_h1_output_i,
                      timer52_output_i, timer50_output_i, low_speed_osc_clock_i, subclock_i};

   // rising edges are taken from the second stage only
   assign src = {st_q.sync2 & ~st_q.prev, 1'b1};

   assign req  = wb_req_i.cyc & wb_req_i.stb & ~st_q.ack;
   assign wr   = req & wb_req_i.we;
   assign pend = (st_q.mcm != st_q.main_clock_status) | (st_q.css != st_q.cpu_clock_status);

   cks_stop_gate u_gate (
      .mcs_i         (st_q.main_clock_status),
      .cls_i         (st_q.cpu_clock_status),
      .pend_i        (pend),
      .ihs_stop_ok_o (ihs_ok),
      .hs_stop_ok_o  (hs_ok),
      .sub_stop_ok_o (sub_ok)
   );

   cks_src_mux u_mux (
      .sel_i  (st_q.sel),
      .src_i  (src),
      .tick_o (mux_tick)
   );

   // ***************************************************************
   // source select fields: write legalisation and read image
   // ***************************************************************
   // an unoffered code is dropped so the field keeps its old, legal value
   for (genvar g = 0; g < cks_pkg::NUM_PERIPH; g++) begin : g_sel
      localparam int RI = g / cks_pkg::FIELDS_PER_REG;
      localparam int FP = (g % cks_pkg::FIELDS_PER_REG) * cks_pkg::FIELD_W;
      logic                      hit;
      logic [cks_pkg::SRC_W-1:0] code;
      assign hit  = wr & wb_req_i.sel[FP/8] &
                    (wb_req_i.adr == (RI == 0 ? cks_pkg::SEL0_ADR : cks_pkg::SEL1_ADR));
      assign code = wb_req_i.dat[FP +: cks_pkg::SRC_W];
      assign sel_wr[g*cks_pkg::SRC_W +: cks_pkg::SRC_W] =
         (hit & cks_pkg::PERMIT[g*cks_pkg::NUM_SRC + int'(code)]) ? code :
         st_q.sel[g*cks_pkg::SRC_W +: cks_pkg::SRC_W];
      assign rd_sel[RI][FP +: cks_pkg::FIELD_W] =
         {1'b0, st_q.sel[g*cks_pkg::SRC_W +: cks_pkg::SRC_W]};
   end
   assign rd_sel[1][31:28] = 4'h0;

   // ***************************************************************
   // read images
   // ***************************************************************
   always_comb begin
      ctrl_rd = 32'h0000_0000;
      ctrl_rd[cks_pkg::CTRL_MAIN_SEL_BIT] = st_q.mcm;
      ctrl_rd[cks_pkg::CTRL_CPU_SEL_BIT]  = st_q.css;
      ctrl_rd[cks_pkg::CTRL_IHS_STOP_BIT] = st_q.ihs_stop;
      ctrl_rd[cks_pkg::CTRL_HS_STOP_BIT]  = st_q.hs_stop;
      ctrl_rd[cks_pkg::CTRL_SUB_SEL_BIT]  = st_q.sub_sel;
      stat_rd = 32'h0000_0000;
      stat_rd[cks_pkg::STAT_MCS_BIT]     = st_q.main_clock_status;
      stat_rd[cks_pkg::STAT_CLS_BIT]     = st_q.cpu_clock_status;
      stat_rd[cks_pkg::STAT_REFUSED_BIT] = st_q.refused;
      stat_rd[cks_pkg::STAT_PEND_BIT]    = pend;
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      logic [31:0] w;
      logic        ctrl_wr;
      w       = wb_req_i.dat;
      ctrl_wr = wr & wb_req_i.sel[0] & (wb_req_i.adr == cks_pkg::CTRL_ADR);
      st_d     = st_q;
      st_d.ack = req;
      st_d.sync1 = async_in;
      st_d.sync2 = st_q.sync1;
      st_d.prev  = st_q.sync2;
      st_d.tick  = mux_tick;
      st_d.sel   = sel_wr;

      // status follows the selection after a fixed lag
      if (pend) begin
         if (st_q.cnt == cks_pkg::SWITCH_CYCLES - 3'h1) begin
            st_d.main_clock_status = st_q.mcm;
            st_d.cpu_clock_status = st_q.css;
            st_d.cnt = 3'h0;
         end else begin
            st_d.cnt = st_q.cnt + 3'h1;
         end
      end else begin
         st_d.cnt = 3'h0;
      end

      // read data; unmapped addresses read zero
      if (req) begin
         if (wb_req_i.adr == cks_pkg::CTRL_ADR) begin
            st_d.rdat = ctrl_rd;
         end else if (wb_req_i.adr == cks_pkg::STAT_ADR) begin
            st_d.rdat = stat_rd;
         end else if (wb_req_i.adr == cks_pkg::SEL0_ADR) begin
            st_d.rdat = rd_sel[0];
         end else if (wb_req_i.adr == cks_pkg::SEL1_ADR) begin
            st_d.rdat = rd_sel[1];
         end else begin
            st_d.rdat = 32'h0000_0000;
         end
      end

      // refused flag is cleared by writing one; a refusal in the same cycle wins
      if (wr & wb_req_i.sel[0] & (wb_req_i.adr == cks_pkg::STAT_ADR) &
          w[cks_pkg::STAT_REFUSED_BIT]) begin
         st_d.refused = 1'b0;
      end

      if (ctrl_wr) begin
         // starting a source is always allowed, stopping needs the interlock
         if (!w[cks_pkg::CTRL_IHS_STOP_BIT]) begin
            st_d.ihs_stop = 1'b0;
         end else if (!st_q.ihs_stop) begin
            if (ihs_ok) begin
               st_d.ihs_stop = 1'b1;
            end else begin
               st_d.refused = 1'b1;
            end
         end
         if (!w[cks_pkg::CTRL_HS_STOP_BIT]) begin
            st_d.hs_stop = 1'b0;
         end else if (!st_q.hs_stop) begin
            if (hs_ok) begin
               st_d.hs_stop = 1'b1;
            end else begin
               st_d.refused = 1'b1;
            end
         end
         if (w[cks_pkg::CTRL_SUB_SEL_BIT]) begin
            st_d.sub_sel = 1'b1;
         end else if (st_q.sub_sel) begin
            if (sub_ok) begin
               st_d.sub_sel = 1'b0;
            end else begin
               st_d.refused = 1'b1;
            end
         end

         // a switch needs no switch in flight and a running target source
         if (w[cks_pkg::CTRL_MAIN_SEL_BIT] != st_q.mcm) begin
            if (!pend && (w[cks_pkg::CTRL_MAIN_SEL_BIT] ? !st_d.hs_stop : !st_d.ihs_stop)) begin
               st_d.mcm = w[cks_pkg::CTRL_MAIN_SEL_BIT];
            end else begin
               st_d.refused = 1'b1;
            end
         end
         if (w[cks_pkg::CTRL_CPU_SEL_BIT] != st_q.css) begin
            if (!pend && (w[cks_pkg::CTRL_CPU_SEL_BIT] ? st_d.sub_sel :
                          (st_d.mcm ? !st_d.hs_stop : !st_d.ihs_stop))) begin
               st_d.css = w[cks_pkg::CTRL_CPU_SEL_BIT];
            end else begin
               st_d.refused = 1'b1;
            end
         end
      end
   end

   // state register
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ***************************************************************
   // outputs, all straight from flops
   // ***************************************************************
   assign wb_rsp_o.ack           = st_q.ack;
   assign wb_rsp_o.dat           = st_q.rdat;
   assign main_clock_status_o    = st_q.main_clock_status;
   assign cpu_clock_status_o     = st_q.cpu_clock_status;
   assign internal_hs_osc_stop_o = st_q.ihs_stop;
   assign high_speed_osc_stop_o  = st_q.hs_stop;
   assign subclock_osc_select_o  = st_q.sub_sel;
   assign periph_tick_o          = st_q.tick;

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence s_ctrl_wr;
      wr & wb_req_i.sel[0] & (wb_req_i.adr == cks_pkg::CTRL_ADR);
   endsequence

   sequence s_main_change;
      $changed(st_q.mcm);
   endsequence

   sequence s_cpu_change;
      $changed(st_q.css);
   endsequence

   AST_IHS_STOP_SAFE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $rose(st_q.ihs_stop) |-> (st_q.main_clock_status | st_q.cpu_clock_status))
      else $error("internal oscillator stopped while cpu ran on it");

   AST_HS_STOP_SAFE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $rose(st_q.hs_stop) |-> (!st_q.main_clock_status | st_q.cpu_clock_status))
      else $error("high-speed source stopped while cpu ran on it");

   AST_SUB_STOP_SAFE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $fell(st_q.sub_sel) |-> !st_q.cpu_clock_status)
      else $error("subclock oscillator stopped while cpu ran on it");

   logic w_ihs_req;
   assign w_ihs_req = wb_req_i.dat[cks_pkg::CTRL_IHS_STOP_BIT];

   AST_IHS_STOP_WRITE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      s_ctrl_wr |-> ((w_ihs_req & ihs_ok) |=> st_q.ihs_stop))
      else $error("permitted internal oscillator stop not taken");

   AST_WDT_SOURCE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      st_q.sel[cks_pkg::WDT_IDX*cks_pkg::SRC_W +: cks_pkg::SRC_W] == cks_pkg::SRC_FRL)
      else $error("watchdog source left the low-speed clock");

   AST_TM00_LEGAL: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      cks_pkg::PERMIT[int'(st_q.sel[2:0])])
      else $error("timer 00 holds a source it may not use");

   AST_MCS_FOLLOW: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      s_main_change |-> !st_q.main_clock_status == st_q.mcm ##2 st_q.main_clock_status == st_q.mcm)
      else $error("main clock status did not follow selection in two cycles");

   AST_CLS_FOLLOW: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      s_cpu_change |-> (st_q.cpu_clock_status != st_q.css) ##2 (st_q.cpu_clock_status == st_q.css))
      else $error("cpu clock status did not follow selection in two cycles");

endmodule : cks_clock_ctrl

/* hdl/cks_pkg.sv */
// package: register map, source codes, permission table and bus carriers of the clock block
package cks_pkg;

   // ***************************************************************
   // register map (byte addresses)
   // ***************************************************************
   localparam logic [7:0] CTRL_ADR = 8'h00;
   localparam logic [7:0] STAT_ADR = 8'h04;
   localparam logic [7:0] SEL0_ADR = 8'h08;
   localparam logic [7:0] SEL1_ADR = 8'h0c;

   // control register fields
   localparam int CTRL_MAIN_SEL_BIT = 0;
   localparam int CTRL_CPU_SEL_BIT  = 1;
   localparam int CTRL_IHS_STOP_BIT = 4;
   localparam int CTRL_HS_STOP_BIT  = 5;
   localparam int CTRL_SUB_SEL_BIT  = 6;

   // status register fields
   localparam int STAT_MCS_BIT     = 0;
   localparam int STAT_CLS_BIT     = 1;
   localparam int STAT_REFUSED_BIT = 2;
   localparam int STAT_PEND_BIT    = 3;

   // reset values: internal oscillator runs, X1 and XT1 are off
   localparam logic RST_IHS_STOP = 1'b0;
   localparam logic RST_HS_STOP  = 1'b1;
   localparam logic RST_SUB_SEL  = 1'b0;
   localparam logic RST_MAIN_SEL = 1'b0;
   localparam logic RST_CPU_SEL  = 1'b0;

   // ***************************************************************
   // peripheral source selection
   // ***************************************************************
   localparam int NUM_PERIPH = 15;
   localparam int NUM_SRC    = 8;
   localparam int NUM_ASYNC  = 7;
   localparam int SRC_W      = 3;
   localparam int FIELD_W    = 4;
   localparam int FIELDS_PER_REG = 8;

   localparam logic [2:0] SRC_FPRS  = 3'h0;
   localparam logic [2:0] SRC_FSUB  = 3'h1;
   localparam logic [2:0] SRC_FRL   = 3'h2;
   localparam logic [2:0] SRC_TIMER50_OUTPUT  = 3'h3;
   localparam logic [2:0] SRC_TIMER52_OUTPUT  = 3'h4;
   localparam logic [2:0] SRC_TIMER_H1_OUTPUT  = 3'h5;
   localparam logic [2:0] SRC_TIMER00_PIN_CLOCK = 3'h6;
   localparam logic [2:0] SRC_TIMER52_PIN_CLOCK  = 3'h7;

   // one byte per peripheral (14 down to 0), bit n set when source code n is offered
   localparam logic [NUM_PERIPH*NUM_SRC-1:0] PERMIT =
      120'h01_07_09_09_01_01_04_03_01_05_09_81_21_01_53;

   // all peripherals start on fprs, the watchdog (peripheral 8) on the low-speed clock
   localparam logic [NUM_PERIPH*SRC_W-1:0] RST_SEL = 45'h000_0200_0000;
   localparam int WDT_IDX = 8;

   // cycles the status flags lag a clock selection change
   localparam logic [2:0] SWITCH_CYCLES = 3'h2;

   // ***************************************************************
   // bus carriers
   // ***************************************************************
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } cks_wb_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } cks_wb_rsp_s;

endpackage : cks_pkg

/* hdl/cks_stop_gate.sv */
// oscillator stop permission check from the settled clock status
`timescale 1ns/1ps
module cks_stop_gate (
   input  wire logic mcs_i,
   input  wire logic cls_i,
   input  wire logic pend_i,
   output logic      ihs_stop_ok_o,
   output logic      hs_stop_ok_o,
   output logic      sub_stop_ok_o
);

   // a pending switchover makes the status stale, so no stop is granted then
   assign ihs_stop_ok_o = ~pend_i & (mcs_i | cls_i);
   assign hs_stop_ok_o  = ~pend_i & (~mcs_i | cls_i);
   assign sub_stop_ok_o = ~pend_i & ~cls_i;

endmodule : cks_stop_gate

/* hdl/cks_src_mux.sv */
// per-peripheral count-enable mux over the offered source ticks
`timescale 1ns/1ps
module cks_src_mux (
   input  wire logic [cks_pkg::NUM_PERIPH*cks_pkg::SRC_W-1:0] sel_i,
   input  wire logic [cks_pkg::NUM_SRC-1:0]                   src_i,
   output logic      [cks_pkg::NUM_PERIPH-1:0]                tick_o
);

   // a code that is not offered gives no tick, even if it ever got stored
   for (genvar g = 0; g < cks_pkg::NUM_PERIPH; g++) begin : g_mux
      logic [cks_pkg::SRC_W-1:0] code;
      assign code      = sel_i[g*cks_pkg::SRC_W +: cks_pkg::SRC_W];
      assign tick_o[g] = src_i[code] & cks_pkg::PERMIT[g*cks_pkg::NUM_SRC + int'(code)];
   end

endmodule : cks_src_mux

/* verif/cks_clock_ctrl_tb.sv */
// testbench: clock control block checked against a behavioural model
`timescale 1ns/1ps
module cks_clock_ctrl_tb;
   // ***************************************************************
   // signals and model state
   // ***************************************************************
   logic                 clock_i;
   logic                 reset_n_i;
   cks_pkg::cks_wb_req_s req_q;
   cks_pkg::cks_wb_rsp_s rsp;
   logic [7:0]           src_q;
   logic                 main_clock_status, cpu_clock_status, ihs, hs, sub;
   logic [14:0]          tick;
   logic                 cnt_en;
   logic [31:0]          rd;
   int                   error_cnt, total_checks, seed, cyc_cnt, tick_cnt, cnt_idx;
   int                   m_main, m_cpu, m_ihs, m_hs, m_sub, m_ref;
   int                   m_sel [15];
   // offered sources per peripheral, bit n set when code n may be chosen
   logic [7:0]           perm [15] = '{8'h53, 8'h01, 8'h21, 8'h81, 8'h09, 8'h05, 8'h01,
                                       8'h03, 8'h04, 8'h01, 8'h01, 8'h09, 8'h09, 8'h07, 8'h01};
   int                   srcp [8] = '{1, 0, 8, 4, 0, 2, 0, 3};
   int                   dir [9] = '{2, 3, 0, 4, 1, 4, 2, 1, 3};

   cks_clock_ctrl dut (
      .clock_i               (clock_i),
      .reset_n_i             (reset_n_i),
      .wb_req_i              (req_q),
      .wb_rsp_o              (rsp),
      .subclock_i            (src_q[1]),
      .low_speed_osc_clock_i (src_q[2]),
      .timer50_output_i      (src_q[3]),
      .timer52_output_i      (src_q[4]),
      .timer_h1_output_i     (src_q[5]),
      .timer00_pin_clock_i   (src_q[6]),
      .timer52_pin_clock_i   (src_q[7]),
      .main_clock_status_o   (main_clock_status),
      .cpu_clock_status_o    (cpu_clock_status),
      .internal_hs_osc_stop_o(ihs),
      .high_speed_osc_stop_o (hs),
      .subclock_osc_select_o (sub),
      .periph_tick_o         (tick)
   );

   // clock and tick counter; the counter reads ticks before this edge lands
   initial clock_i = 1'b0;
   always #25 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      if (cnt_en) begin
         cyc_cnt  <= cyc_cnt + 1;
         tick_cnt <= tick_cnt + int'(tick[cnt_idx]);
      end
   end

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   // one classic cycle; ack and read data are taken at the rising edge that sees ack high
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rdat);
      int n = 0;
      @(posedge clock_i);
      req_q <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
      do begin
         @(posedge clock_i);
         n++;
      end while (rsp.ack !== 1'b1 && n < 50);
      check({31'h0, rsp.ack}, 32'h1, "bus answer");
      rdat = rsp.dat;
      req_q <= '0;
   endtask : wb

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string msg);
      wb(1'b0, adr, 32'h0, rd);
      check(rd, exp, msg);
   endtask : rd_chk

   function automatic logic [31:0] ctrl_w();
      return {25'h0, m_sub[0], m_hs[0], m_ihs[0], 2'b00, m_cpu[0], m_main[0]};
   endfunction : ctrl_w

   function automatic logic [31:0] sel_w(input int r);
      logic [31:0] w;
      w = '0;
      for (int g = 0; g < 8; g++) begin
         if (r * 8 + g < 15) w[4*g +: 3] = m_sel[r*8+g][2:0];
      end
      return w;
   endfunction : sel_w

   task automatic model_reset();
      {m_main, m_cpu, m_ihs, m_hs, m_sub, m_ref} =
         {32'sd0, 32'sd0, 32'sd0, 32'sd1, 32'sd0, 32'sd0};
      foreach (m_sel[i]) m_sel[i] = 0;
      m_sel[8] = 2;
   endtask : model_reset

   task automatic state_chk();
      @(negedge clock_i);
      check({27'h0, main_clock_status, cpu_clock_status, ihs, hs, sub},
            {27'h0, m_main[0], m_cpu[0], m_ihs[0], m_hs[0], m_sub[0]}, "pins");
      rd_chk(cks_pkg::STAT_ADR, {29'h0, m_ref[0], m_cpu[0], m_main[0]}, "stat");
      rd_chk(cks_pkg::CTRL_ADR, ctrl_w(), "ctrl");
   endtask : state_chk

   // flip one control bit: 0 main, 1 cpu, 2 ihs stop, 3 hs stop, 4 xt1 run
   task automatic step(input int k);
      int          ok;
      int          bpos [5] = '{0, 1, 4, 5, 6};
      logic [31:0] w;
      case (k)
         0: ok = m_main ? !m_ihs : !m_hs;
         1: ok = m_cpu ? (m_main ? !m_hs : !m_ihs) : m_sub;
         2: ok = m_ihs || m_main || m_cpu;
         3: ok = m_hs || !m_main || m_cpu;
         default: ok = !m_sub || !m_cpu;
      endcase
      w = ctrl_w() ^ (32'h1 << bpos[k]);
      wb(1'b1, cks_pkg::CTRL_ADR, w, rd);
      @(negedge clock_i);
      // status lags the select, so the old value still stands here
      check({30'h0, main_clock_status, cpu_clock_status}, {30'h0, m_main[0], m_cpu[0]}, "status lag");
      if (ok != 0) begin
         m_sub  = int'(w[6]);
         m_hs   = int'(w[5]);
         m_ihs  = int'(w[4]);
         m_cpu  = int'(w[1]);
         m_main = int'(w[0]);
      end else begin
         m_ref = 1;
      end
      repeat (4) @(posedge clock_i);
      state_chk();
   endtask : step

   task automatic set_sel(input int p, input int c);
      int          r;
      logic [31:0] w;
      r = p / 8;
      w = sel_w(r);
      w[4*(p%8) +: 3] = c[2:0];
      wb(1'b1, r ? cks_pkg::SEL1_ADR : cks_pkg::SEL0_ADR, w, rd);
      if (perm[p][c] === 1'b1) m_sel[p] = c;
      rd_chk(r ? cks_pkg::SEL1_ADR : cks_pkg::SEL0_ADR, sel_w(r), "sel field");
   endtask : set_sel

   // selected source pulses n times, the others n+3 times, so a wrong pick shows
   task automatic tick_run(input int s, input int p, input int n);
      set_sel(p, s);
      cnt_idx <= p;
      @(posedge clock_i);
      {cyc_cnt, tick_cnt} <= {32'sd0, 32'sd0};
      cnt_en <= 1'b1;
      for (int i = 0; i < n + 3; i++) begin
         @(posedge clock_i);
         src_q <= (i < n) ? 8'hff : ~(8'h01 << s);
         repeat (2) @(posedge clock_i);
         src_q <= 8'h00;
         @(posedge clock_i);
      end
      repeat (8) @(posedge clock_i);
      cnt_en <= 1'b0;
      @(negedge clock_i);
      check(tick_cnt, (s == 0) ? cyc_cnt : n, "tick count");
   endtask : tick_run

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results

   // ***************************************************************
   // tests
   // ***************************************************************
   // watchdog: the whole sequence needs well under this many cycles
   initial begin
      repeat (30000) @(posedge clock_i);
      error_cnt++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      results();
   end

   initial begin
      {reset_n_i, req_q, src_q, cnt_en, cnt_idx} = '0;
      {error_cnt, total_checks} = {32'sd0, 32'sd0};
      seed = 81;
      model_reset();
      repeat (2) @(posedge clock_i);
      reset_n_i <= 1'b1;
      state_chk();
      rd_chk(cks_pkg::SEL0_ADR, 32'h0, "sel0 reset");
      rd_chk(cks_pkg::SEL1_ADR, 32'h2, "sel1 reset");
      wb(1'b1, 8'h10, 32'hffffffff, rd);
      rd_chk(8'h10, 32'h0, "unmapped");
      state_chk();
      $display("test reset and map done");
      // directed walk through refused and allowed stops and allowed switches
      foreach (dir[i]) step(dir[i]);
      $display("test interlock walk done");
      for (int i = 0; i < 60; i++) begin
         int k;
         k = {$random(seed)} % 6;
         if (k == 5) begin
            wb(1'b1, cks_pkg::STAT_ADR, 32'h4, rd);
            m_ref = 0;
            state_chk();
         end else step(k);
      end
      $display("test random interlock done");
      for (int p = 0; p < 15; p++) begin
         for (int c = 0; c < 8; c++) set_sel(p, c);
      end
      $display("test source codes done");
      // back to the reset clocking so pin clocks are safe to use
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      reset_n_i <= 1'b1;
      model_reset();
      state_chk();
      for (int s = 0; s < 8; s++) tick_run(s, srcp[s], 1 + {$random(seed)} % 5);
      $display("test source ticks done");
      results();
   end
endmodule : cks_clock_ctrl_tb
